/* File: verilog/swk_top.sv */
// soft power wake controller: enables, wake status, power request pin
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module swk_top (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ring_one_pin,
  input  wire logic        ring_two_pin,
  input  wire logic        keyboard_clock_pin,
  input  wire logic        mouse_clock_pin,
  input  wire logic        infrared_rx_pin,
  input  wire logic        uart_one_rx_pin,
  input  wire logic        uart_two_rx_pin,
  input  wire logic        button_n_pin,
  input  wire logic        rtc_alarm,
  input  wire logic        alarm_two,
  input  wire logic        group_irq_one_state,
  input  wire logic        group_irq_two_state,
  input  wire logic        power_request_n_i,
  output logic             power_request_n_o,
  output logic             power_request_n_oe_n,
  output logic             power_good,
  output logic             power_off_request,
  output logic             irq
);

  logic rst_meta_ff;
  logic rst_n_ff;

  // async assert, synchronous release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  logic [swk_pkg::PIN_N-1:0] pins;
  logic [swk_pkg::PIN_N-1:0] pin_level;
  logic [swk_pkg::PIN_N-1:0] pin_fall;

  assign pins = {power_request_n_i,
                 button_n_pin,
                 uart_two_rx_pin,
                 uart_one_rx_pin,
                 infrared_rx_pin,
                 mouse_clock_pin,
                 keyboard_clock_pin,
                 ring_two_pin,
                 ring_one_pin};

  swk_pin_sync #(
    .W (swk_pkg::PIN_N)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_ff),
    .pin     (pins),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  logic ring_one_event;
  logic ring_two_event;
  logic keyboard_clock_event;
  logic mouse_clock_event;
  logic infrared_receive_event;
  logic uart_one_rx_event;
  logic uart_two_rx_event;
  logic button_event;
  logic pin_level_power;

  assign ring_one_event         = pin_fall[0];
  assign ring_two_event         = pin_fall[1];
  assign keyboard_clock_event   = pin_fall[2];
  assign mouse_clock_event      = pin_fall[3];
  assign infrared_receive_event = pin_fall[4];
  assign uart_one_rx_event      = pin_fall[5];
  assign uart_two_rx_event      = pin_fall[6];
  assign button_event           = pin_fall[7];
  assign pin_level_power        = pin_level[8];

  // internal sources share this clock, no synchroniser needed
  logic rtc_alarm_ff;
  logic alarm_two_ff;
  logic rtc_alarm_event;
  logic alarm_two_event;

  assign rtc_alarm_event = rtc_alarm & ~rtc_alarm_ff;
  assign alarm_two_event = alarm_two & ~alarm_two_ff;

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rtc_alarm_ff <= 1'b0;
      alarm_two_ff <= 1'b0;
    end else begin
      rtc_alarm_ff <= rtc_alarm;
      alarm_two_ff <= alarm_two;
    end
  end

  logic [7:0] en_one_ff;
  logic [7:0] en_two_ff;
  logic [7:0] st_one_ff;
  logic [7:0] st_two_ff;
  logic [2:0] irq_st_ff;
  logic [2:0] irq_mask_ff;
  logic [7:0] st_one_view;
  logic       wr_en_one;
  logic       wr_en_two;
  logic       wr_irq_st;
  logic       wr_irq_mask;
  logic       rd_st_one;
  logic       rd_st_two;

  swk_apb_slave u_apb (
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .en_one      (en_one_ff),
    .en_two      (en_two_ff),
    .st_one      (st_one_view),
    .st_two      (st_two_ff),
    .irq_st      (irq_st_ff),
    .irq_mask    (irq_mask_ff),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .wr_en_one   (wr_en_one),
    .wr_en_two   (wr_en_two),
    .wr_irq_st   (wr_irq_st),
    .wr_irq_mask (wr_irq_mask),
    .rd_st_one   (rd_st_one),
    .rd_st_two   (rd_st_two)
  );

  logic [7:0] nxt_en_one;
  logic [7:0] nxt_en_two;

  // reserved enable bits hold zero
  assign nxt_en_one = wr_en_one ? pwdata[7:0] : en_one_ff; // R02
  assign nxt_en_two = wr_en_two ?
                      (pwdata[7:0] & swk_pkg::EN_TWO_MASK) : en_two_ff; // R03

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      en_one_ff <= swk_pkg::RST_EN_ONE;
      en_two_ff <= swk_pkg::RST_EN_TWO; // R04 R05 R06
    end else begin
      en_one_ff <= nxt_en_one;
      en_two_ff <= nxt_en_two;
    end
  end

  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] keep_one;
  logic [7:0] keep_two;
  logic [7:0] nxt_st_one;
  logic [7:0] nxt_st_two;

  assign set_one = {rtc_alarm_event, // R10
                    infrared_receive_event,
                    2'b00,
                    mouse_clock_event,
                    keyboard_clock_event,
                    ring_two_event,
                    ring_one_event}; // R08

  assign set_two = {3'b000,
                    alarm_two_event,
                    1'b0,
                    button_event,
                    uart_two_rx_event,
                    uart_one_rx_event}; // R13

  // a new edge in the reading cycle survives the clear
  assign keep_one = rd_st_one ? 8'h00 : st_one_ff; // R09
  assign keep_two = rd_st_two ? 8'h00 : st_two_ff; // R13
  assign nxt_st_one = (keep_one | set_one) & swk_pkg::ST_ONE_LATCH;
  assign nxt_st_two = (keep_two | set_two) & swk_pkg::ST_TWO_LATCH;

  // group irq bits are live, never stored, so a read cannot clear them
  assign st_one_view = {st_one_ff[7:6],
                        group_irq_two_state,
                        group_irq_one_state,
                        st_one_ff[3:0]}; // R11 R07

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_one_ff <= swk_pkg::RST_STATUS;
      st_two_ff <= swk_pkg::RST_STATUS;
    end else begin
      st_one_ff <= nxt_st_one;
      st_two_ff <= nxt_st_two;
    end
  end

  // enable fields by name; reserved bits of enable two get no wire
  logic ring_one_wake_en;
  logic ring_two_wake_en;
  logic keyboard_clock_wake_en;
  logic mouse_clock_wake_en;
  logic group_irq_one_wake_en;
  logic group_irq_two_wake_en;
  logic infrared_rx_two_wake_en;
  logic rtc_alarm_wake_en;
  logic uart_one_rx_wake_en;
  logic uart_two_rx_wake_en;
  logic alarm_two_wake_en;
  logic power_good_select;
  logic button_off_en;

  assign ring_one_wake_en        = en_one_ff[swk_pkg::B_RING_ONE]; // R02
  assign ring_two_wake_en        = en_one_ff[swk_pkg::B_RING_TWO];
  assign keyboard_clock_wake_en  = en_one_ff[swk_pkg::B_KBD_CLK];
  assign mouse_clock_wake_en     = en_one_ff[swk_pkg::B_MOUSE_CLK];
  assign group_irq_one_wake_en   = en_one_ff[swk_pkg::B_GRP_ONE];
  assign group_irq_two_wake_en   = en_one_ff[swk_pkg::B_GRP_TWO];
  assign infrared_rx_two_wake_en = en_one_ff[swk_pkg::B_IR_RX];
  assign rtc_alarm_wake_en       = en_one_ff[swk_pkg::B_RTC];
  assign uart_one_rx_wake_en     = en_two_ff[swk_pkg::B_RX_ONE]; // R03
  assign uart_two_rx_wake_en     = en_two_ff[swk_pkg::B_RX_TWO];
  assign alarm_two_wake_en       = en_two_ff[swk_pkg::B_ALARM_TWO]; // R04
  assign power_good_select       = en_two_ff[swk_pkg::B_PG_SEL]; // R05
  assign button_off_en           = en_two_ff[swk_pkg::B_OFF_EN]; // R06

  logic wake_ring_one;
  logic wake_ring_two;
  logic wake_keyboard;
  logic wake_mouse;
  logic wake_group_one;
  logic wake_group_two;
  logic wake_infrared;
  logic wake_rtc;
  logic wake_rx_one;
  logic wake_rx_two;
  logic wake_alarm_two;
  logic wake_one;
  logic wake_two;
  logic wake_any;
  logic pg_sel;
  logic off_en;

  // a disabled source still shows its status but never requests power
  assign wake_ring_one  = st_one_view[swk_pkg::B_RING_ONE] &
                          ring_one_wake_en;
  assign wake_ring_two  = st_one_view[swk_pkg::B_RING_TWO] &
                          ring_two_wake_en;
  assign wake_keyboard  = st_one_view[swk_pkg::B_KBD_CLK] &
                          keyboard_clock_wake_en;
  assign wake_mouse     = st_one_view[swk_pkg::B_MOUSE_CLK] &
                          mouse_clock_wake_en;
  assign wake_group_one = st_one_view[swk_pkg::B_GRP_ONE] &
                          group_irq_one_wake_en;
  assign wake_group_two = st_one_view[swk_pkg::B_GRP_TWO] &
                          group_irq_two_wake_en;
  assign wake_infrared  = st_one_view[swk_pkg::B_IR_RX] &
                          infrared_rx_two_wake_en;
  assign wake_rtc       = st_one_view[swk_pkg::B_RTC] &
                          rtc_alarm_wake_en;
  assign wake_rx_one    = st_two_ff[swk_pkg::B_RX_ONE] &
                          uart_one_rx_wake_en;
  assign wake_rx_two    = st_two_ff[swk_pkg::B_RX_TWO] &
                          uart_two_rx_wake_en;
  assign wake_alarm_two = st_two_ff[swk_pkg::B_ALARM_TWO] &
                          alarm_two_wake_en;

  assign pg_sel = power_good_select;
  assign off_en = button_off_en;

  // button bit is status only and never requests power
  assign wake_one = wake_ring_one | wake_ring_two | wake_keyboard |
                    wake_mouse | wake_group_one | wake_group_two |
                    wake_infrared | wake_rtc; // R01
  assign wake_two = wake_rx_one | wake_rx_two | wake_alarm_two; // R01
  assign wake_any = wake_one | wake_two; // R12

  logic req_n_ff;
  logic pgood_ff;
  logic off_req_ff;

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      req_n_ff   <= 1'b1;
      pgood_ff   <= 1'b0;
      off_req_ff <= 1'b0;
    end else begin
      req_n_ff   <= ~wake_any; // R12
      pgood_ff   <= pg_sel & pin_level_power; // R05
      off_req_ff <= off_en & button_event; // R06
    end
  end

  // in power good mode the pin is released and sampled instead
  assign power_request_n_o    = req_n_ff;
  assign power_request_n_oe_n = pg_sel; // R05
  assign power_good           = pgood_ff;
  assign power_off_request    = off_req_ff;

  logic       irq_from_one;
  logic       irq_from_two;
  logic       irq_from_button;
  logic [2:0] irq_ev;
  logic [2:0] irq_pending;
  logic [2:0] nxt_irq_st;
  logic [2:0] nxt_irq_mask;

  // a button press is a status two latch too, so it raises both bits
  assign irq_from_one    = |set_one;
  assign irq_from_two    = |(set_two & swk_pkg::ST_TWO_LATCH);
  assign irq_from_button = button_event;
  assign irq_ev = {irq_from_button, irq_from_two, irq_from_one};

  // write one clears, a same-cycle event wins
  assign nxt_irq_st = wr_irq_st ?
                      ((irq_st_ff & ~pwdata[2:0]) | irq_ev) :
                      (irq_st_ff | irq_ev);
  assign nxt_irq_mask = wr_irq_mask ? pwdata[2:0] : irq_mask_ff;

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_st_ff   <= swk_pkg::RST_IRQ;
      irq_mask_ff <= swk_pkg::RST_IRQ;
    end else begin
      irq_st_ff   <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  assign irq_pending = irq_st_ff & irq_mask_ff;
  assign irq         = |irq_pending;

endmodule : swk_top

/* File: inc/swk_pkg.sv */
// constants for the soft power wake controller
// Summary of operation
// R01: an enable bit at 1 lets its source raise the power request; 0 blocks it
// R02: enable one: ring1, ring2, kbd clk, mouse clk, grp irq1, grp irq2, ir, rtc
// R03: enable two: bit0 uart1 rx, bit1 uart2 rx; bits 3:2 and 5 reserved
// R04: enable two bit4 enables rtc alarm two wake, reset to 0
// R05: enable two bit6 turns power request pin into power good; reset 0
// R06: enable two bit7 resets to 1 and allows button power off
// R07: status one bits 7:6 and 3:0 show which wake source occurred since last clear
// R08: ring, keyboard, mouse and infrared falling edges set and hold status
// R09: reading status one clears its latched pin edge bits
// R10: status bit7 latches the rtc alarm and clears on status one read
// R11: status bits 4 and 5 show group irqs live; a read never clears them
// R12: power request asserts low on the OR of all enabled wake events
// R13: status two latches uart rx falls and alarm two; read clears them
package swk_pkg;
  localparam logic [7:0] IDX_EN_ONE   = 8'hB0;
  localparam logic [7:0] IDX_EN_TWO   = 8'hB1;
  localparam logic [7:0] IDX_ST_ONE   = 8'hB2;
  localparam logic [7:0] IDX_ST_TWO   = 8'hB3;
  localparam logic [7:0] IDX_IRQ_ST   = 8'hB8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hB9;

  localparam logic [7:0] RST_EN_ONE   = 8'h00;
  localparam logic [7:0] RST_EN_TWO   = 8'h80;
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [2:0] RST_IRQ      = 3'h0;

  localparam logic [7:0] EN_TWO_MASK  = 8'hD3;
  localparam logic [7:0] ST_ONE_LATCH = 8'hCF;
  localparam logic [7:0] ST_TWO_LATCH = 8'h17;
  localparam logic [7:0] ST_TWO_WAKE  = 8'h13;

  localparam int B_RING_ONE  = 0;
  localparam int B_RING_TWO  = 1;
  localparam int B_KBD_CLK   = 2;
  localparam int B_MOUSE_CLK = 3;
  localparam int B_GRP_ONE   = 4;
  localparam int B_GRP_TWO   = 5;
  localparam int B_IR_RX     = 6;
  localparam int B_RTC       = 7;
  localparam int B_RX_ONE    = 0;
  localparam int B_RX_TWO    = 1;
  localparam int B_BUTTON    = 2;
  localparam int B_ALARM_TWO = 4;
  localparam int B_PG_SEL    = 6;
  localparam int B_OFF_EN    = 7;

  localparam int B_IRQ_ONE   = 0;
  localparam int B_IRQ_TWO   = 1;
  localparam int B_IRQ_OFF   = 2;

  localparam int PIN_N       = 9;
  localparam int ADDR_W      = 12;

  function automatic logic hit(input logic [11:0] addr,
                               input logic [7:0]  idx);
    hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx);
  endfunction : hit
endpackage : swk_pkg

/* File: verilog/swk_pin_sync.sv */
// three flop pin synchroniser with stable level and falling edge pulse
`timescale 1ns/1ps
module swk_pin_sync #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] q1_ff;
  logic [W-1:0] q2_ff;
  logic [W-1:0] q3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] nxt_level;

  // a change counts only when stages two and three agree
  assign nxt_level = (q2_ff & q3_ff) | (level_ff & (q2_ff | q3_ff));
  assign level     = level_ff;
  assign fall      = level_ff & ~nxt_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q1_ff    <= '1;
      q2_ff    <= '1;
      q3_ff    <= '1;
      level_ff <= '1;
    end else begin
      q1_ff    <= pin;
      q2_ff    <= q1_ff;
      q3_ff    <= q2_ff;
      level_ff <= nxt_level;
    end
  end
endmodule : swk_pin_sync

/* File: verilog/swk_apb_slave.sv */
// apb decode: write strobes, read-to-clear strobes, read data select
`timescale 1ns/1ps
module swk_apb_slave (
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [7:0]  en_one,
  input  wire logic [7:0]  en_two,
  input  wire logic [7:0]  st_one,
  input  wire logic [7:0]  st_two,
  input  wire logic [2:0]  irq_st,
  input  wire logic [2:0]  irq_mask,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_en_one,
  output logic             wr_en_two,
  output logic             wr_irq_st,
  output logic             wr_irq_mask,
  output logic             rd_st_one,
  output logic             rd_st_two
);
  logic       acc;
  logic       h_e1;
  logic       h_e2;
  logic       h_s1;
  logic       h_s2;
  logic       h_is;
  logic       h_im;
  logic       mapped;
  logic [7:0] rsel;

  assign acc  = psel & penable;
  assign h_e1 = swk_pkg::hit(paddr, swk_pkg::IDX_EN_ONE);
  assign h_e2 = swk_pkg::hit(paddr, swk_pkg::IDX_EN_TWO);
  assign h_s1 = swk_pkg::hit(paddr, swk_pkg::IDX_ST_ONE);
  assign h_s2 = swk_pkg::hit(paddr, swk_pkg::IDX_ST_TWO);
  assign h_is = swk_pkg::hit(paddr, swk_pkg::IDX_IRQ_ST);
  assign h_im = swk_pkg::hit(paddr, swk_pkg::IDX_IRQ_MASK);
  assign mapped = h_e1 | h_e2 | h_s1 | h_s2 | h_is | h_im;

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  assign wr_en_one   = acc & pwrite & h_e1;
  assign wr_en_two   = acc & pwrite & h_e2;
  assign wr_irq_st   = acc & pwrite & h_is;
  assign wr_irq_mask = acc & pwrite & h_im;
  assign rd_st_one   = acc & ~pwrite & h_s1;
  assign rd_st_two   = acc & ~pwrite & h_s2;

  assign rsel = h_e1 ? en_one :
                h_e2 ? en_two :
                h_s1 ? st_one :
                h_s2 ? st_two :
                h_is ? {5'h00, irq_st} :
                h_im ? {5'h00, irq_mask} : 8'h00;
  assign prdata = {24'h000000, rsel};
endmodule : swk_apb_slave

/* File: tb/swk_supply_model.sv */
// behavioural supply switch behind the power request pin
`timescale 1ns/1ps
module swk_supply_model #(
  parameter int DLY = 3
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic req_n,
  input  wire logic oe_n,
  input  wire logic off,
  output logic      pin
);
  int   cnt_ff;
  logic on_ff;
  // supply comes up only once the request has been low a while
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 0;
      on_ff  <= 1'h0;
    end else if (off) begin
      cnt_ff <= 0;
      on_ff  <= 1'h0;
    end else if (!oe_n && !req_n) begin
      cnt_ff <= cnt_ff + 1;
      on_ff  <= on_ff || cnt_ff >= DLY;
    end
  end
  // released pin shows supply good, else it follows the driver
  assign pin = oe_n ? on_ff : req_n;
endmodule : swk_supply_model

/* File: tb/swk_properties.sv */
// port checker of the wake controller
`timescale 1ns/1ps
module swk_properties (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_request_n_oe_n,
  input wire logic        power_good,
  input wire logic        power_off_request,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  wire known = paddr inside {12'h2C0, 12'h2C4, 12'h2C8, 12'h2CC,
                             12'h2E0, 12'h2E4};
  err_unmapped_a: assert property (acc && !known |-> pslverr)
    else $error("unmapped access not refused");
  err_phase_a: assert property (pslverr |-> acc && !known)
    else $error("error flag outside unmapped access");
  upper_zero_a: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  en_two_rsvd_a: assert property (rd && paddr == 12'h2C4 |->
    (prdata[7:0] & 8'h2C) == 8'h0) else $error("reserved bits set");
  pg_write_oe_a: assert property (acc && pwrite && paddr == 12'h2C4
    |=> power_request_n_oe_n == $past(pwdata[6]))
    else $error("pin enable does not follow select");
  good_sel_a: assert property (power_good |->
    $past(power_request_n_oe_n)) else $error("power good while driving");
  off_pulse_a: assert property (power_off_request |=>
    !power_off_request) else $error("power off not a pulse");
  st_two_rsvd_a: assert property (rd && paddr == 12'h2CC |->
    prdata[7:5] == 3'h0 && !prdata[3]) else $error("status two reserved");
  irq_masked_a: assert property (rd && paddr == 12'h2E4 &&
    prdata[2:0] == 3'h0 |-> !irq) else $error("irq while fully masked");
  ready_access_a: assert property (acc |-> pready)
    else $error("access phase without ready");
endmodule : swk_properties

bind swk_top swk_properties u_props (.clk_sys, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .power_request_n_oe_n, .power_good, .power_off_request, .irq);

/* File: tb/tb.sv */
// self-checking bench of the soft power wake controller
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } swk_row_t;
  localparam swk_row_t ROWS [6] = '{
    '{12'h2C0, 32'hFF, 32'hFF, 1'h0}, '{12'h2C4, 32'hFF, 32'hD3, 1'h0},
    '{12'h2C4, 32'h00, 32'h00, 1'h0}, '{12'h2E4, 32'h00, 32'h00, 1'h0},
    '{12'h2E4, 32'h07, 32'h07, 1'h0}, '{12'h100, 32'hFF, 32'h00, 1'h1}};
  localparam logic [11:0] EA [9] = '{12'h2C8, 12'h2C8, 12'h2C8, 12'h2C8,
    12'h2C8, 12'h2CC, 12'h2CC, 12'h2C8, 12'h2CC};
  localparam logic [7:0] EM [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40,
    8'h01, 8'h02, 8'h80, 8'h10};
  localparam logic [11:0] RA [6] = '{12'h2C0, 12'h2C4, 12'h2C8, 12'h2CC,
    12'h2E0, 12'h2E4};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00};
  logic        clk_sys, rstn, psel, penable, pwrite, grp1, grp2, e, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pin_in, req_o, oe_n, pgood, poff, irq;
  logic [9:0]  ev;
  int          n_errors, checked;

  swk_top dut (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ring_one_pin(~ev[0]),
    .ring_two_pin(~ev[1]), .keyboard_clock_pin(~ev[2]),
    .mouse_clock_pin(~ev[3]), .infrared_rx_pin(~ev[4]),
    .uart_one_rx_pin(~ev[5]), .uart_two_rx_pin(~ev[6]),
    .rtc_alarm(ev[7]), .alarm_two(ev[8]), .button_n_pin(~ev[9]),
    .group_irq_one_state(grp1), .group_irq_two_state(grp2),
    .power_request_n_i(pin_in), .power_request_n_o(req_o),
    .power_request_n_oe_n(oe_n), .power_good(pgood),
    .power_off_request(poff), .irq);
  swk_supply_model u_sup (.clk_sys, .rstn, .req_n(req_o), .oe_n,
    .off(poff), .pin(pin_in));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // holds the request until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    if (pready !== 1'h1) begin
      n_errors++;
      complete_run;
    end
  endtask : apb

  function automatic logic pick(input int s);
    case (s)
      0: pick = req_o;
      1: pick = pgood;
      default: pick = poff;
    endcase
  endfunction : pick

  task wt(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    if (pick(s) !== v) begin
      n_errors++;
      $display("wrong value wait %0d expected %h seen %h", s, v, pick(s));
      complete_run;
    end
  endtask : wt

  task settle;
    @(posedge clk_sys);
  endtask : settle

  initial begin
    rstn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h0; pwdata = 32'h0; ev = 10'h0; grp1 = 1'h0; grp2 = 1'h0;
    n_errors = 0; checked = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk("request", 32'h1, 32'(req_o));
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, RA[i], 32'h0);
      chk("reset value", 32'(RV[i]), q);
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, ROWS[i].a, ROWS[i].d);
      apb(1'h0, ROWS[i].a, 32'h0);
      chk("readback", ROWS[i].x, q);
      chk("error", 32'(ROWS[i].e), 32'(e));
    end
    $display("test registers done");
    apb(1'h1, 12'h2C0, 32'hFF);
    apb(1'h1, 12'h2C4, 32'h93);
    for (int i = 0; i < 9; i++) begin
      ev[i] <= 1'h1;
      wt(0, 1'h0);
      ev[i] <= 1'h0;
      apb(1'h0, EA[i], 32'h0);
      chk("status", 32'(EM[i]), q);
      wt(0, 1'h1);
      apb(1'h0, EA[i], 32'h0);
      chk("cleared", 32'h0, q);
    end
    chk("irq", 32'h1, 32'(irq));
    apb(1'h1, 12'h2E0, 32'h7);
    settle;
    chk("irq", 32'h0, 32'(irq));
    $display("test wake sources done");
    apb(1'h1, 12'h2C0, 32'h0);
    ev[2] <= 1'h1;
    repeat (10) @(posedge clk_sys);
    chk("request", 32'h1, 32'(req_o));
    ev[2] <= 1'h0;
    apb(1'h0, 12'h2C8, 32'h0);
    chk("latched", 32'h4, q);
    apb(1'h1, 12'h2C0, 32'h10);
    grp1 <= 1'h1;
    wt(0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'h0, 12'h2C8, 32'h0);
      chk("live", 32'h10, q);
    end
    grp1 <= 1'h0;
    wt(0, 1'h1);
    apb(1'h0, 12'h2C8, 32'h0);
    chk("live", 32'h0, q);
    $display("test disabled and live done");
    apb(1'h1, 12'h2E0, 32'h7);
    apb(1'h1, 12'h2C4, 32'hC0);
    settle;
    chk("pin release", 32'h1, 32'(oe_n));
    wt(1, 1'h1);
    ev[9] <= 1'h1;
    wt(2, 1'h1);
    ev[9] <= 1'h0;
    wt(1, 1'h0);
    apb(1'h0, 12'h2E0, 32'h0);
    // the button also counts as a status two latch event
    chk("irq status", 32'h6, q);
    chk("irq", 32'h1, 32'(irq));
    apb(1'h1, 12'h2E4, 32'h1);
    settle;
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'h1, 12'h2E0, 32'h6);
    apb(1'h1, 12'h2E4, 32'h7);
    settle;
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'h1, 12'h2C4, 32'h40);
    ev[9] <= 1'h1;
    seen = 1'h0;
    repeat (10) begin
      @(posedge clk_sys);
      seen = seen | poff;
    end
    chk("power off", 32'h0, 32'(seen));
    ev[9] <= 1'h0;
    apb(1'h0, 12'h2CC, 32'h0);
    chk("button", 32'h4, q);
    $display("test power good and button done");
    complete_run;
  end
endmodule : tb
